// >>> pkg/hlis_consts.vh
// hlis_consts.vh: offsets, bit positions and reset values for the
// level-change interrupt status latch.
// assumes: included by bare name from the core file; definitions only.
// Summary of operation
// - bit 7 second byte: channel status valid change
// - bit 6 second byte: internal mute change
// - bit 5 second byte: AV mute change
// - bit 4 second byte: audio channel mode change
// - bit 3 second byte: HDMI/DVI mode change
// - bit 2 second byte: general control packet change
// - bit 1 second byte: clock regeneration packet change
// - bit 0 second byte: gamut metadata change
// - bit 7 third byte: port B cable change
// - bit 6 third byte: port A PLL lock change
// - flags stay set until explicitly cleared
// - flag raises an interrupt only when a mask enables it
// - flags reset to zero; one means changed
// - third byte groups eight port cable, clock and video lock flags; bit 3 is held zero and never sets
// - bit 5 third byte: port B PLL lock change
`ifndef HLIS_CONSTS_VH
`define HLIS_CONSTS_VH

// printed offsets are register indices; byte address is index times four
`define HLIS_IDX_STATUS2 8'h66
`define HLIS_IDX_STATUS3 8'h6B
`define HLIS_ADDR_STATUS2 12'h198
`define HLIS_ADDR_STATUS3 12'h1AC
`define HLIS_ADDR_CLEAR2 12'h1B0
`define HLIS_ADDR_CLEAR3 12'h1B4
`define HLIS_ADDR_MASK1_2 12'h1B8
`define HLIS_ADDR_MASK1_3 12'h1BC
`define HLIS_ADDR_MASK2_2 12'h1C0
`define HLIS_ADDR_MASK2_3 12'h1C4
`define HLIS_ADDR_RAW2 12'h1C8
`define HLIS_ADDR_RAW3 12'h1CC

// field positions, second byte
`define HLIS_BIT_CHAN_STATUS_OK 7
`define HLIS_BIT_INNER_SILENCE 6
`define HLIS_BIT_SOURCE_SILENCE 5
`define HLIS_BIT_SOUND_LAYOUT 4
`define HLIS_BIT_LINK_TYPE 3
`define HLIS_BIT_GENERAL_CTRL_PKT 2
`define HLIS_BIT_SOUND_CLK_REGEN 1
`define HLIS_BIT_COLOUR_RANGE_META 0
// field positions, third byte
`define HLIS_BIT_PORT2_PLUG 7
`define HLIS_BIT_PORT1_PLL_LOCK 6
`define HLIS_BIT_PORT2_PLL_LOCK 5
`define HLIS_BIT_PORT1_CLK_SEEN 4
`define HLIS_BIT_PORT2_CLK_SEEN 3
`define HLIS_BIT_STEREO_VIDEO 2
`define HLIS_BIT_VSYNC_FILTER_LOCK 1
`define HLIS_BIT_DE_REBUILD_LOCK 0

// reset values
`define HLIS_RST_STATUS 8'h00
`define HLIS_RST_FLAG 1'b0
`define HLIS_RST_MASK 8'h00
`define HLIS_RST_RDATA 32'h00000000

`endif

// >>> core/hlis_status_latch.v
// hlis_status_latch.v: sticky change-detect status bytes with two masked
// interrupt outputs and an APB register slave.
// assumes: raw levels already synchronous to mclk; APB master on mclk.
`timescale 1ns/10ps
`include "hlis_consts.vh"

module hlis_status_latch #(
	parameter ADDR_W = 12
)(
	input wire mclk,
	input wire nrst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire chanStatusOkLevel,
	input wire innerSilenceLevel,
	input wire sourceSilenceLevel,
	input wire soundLayoutLevel,
	input wire linkTypeLevel,
	input wire generalCtrlPktLevel,
	input wire soundClkRegenLevel,
	input wire colourRangeMetaLevel,
	input wire port2PlugLevel,
	input wire port1PllLockLevel,
	input wire port2PllLockLevel,
	input wire port1ClkSeenLevel,
	input wire stereoVideoLevel,
	input wire vsyncFilterLockLevel,
	input wire deRebuildLockLevel,
	output wire firstIrqOutput,
	output wire secondIrqOutput
);

	// raw levels gathered into the two byte layouts
	wire [7:0] raw2;
	wire [7:0] raw3;
	reg rawValid_q;
	wire [7:0] flagByte2;
	wire [7:0] flagByte3;
	reg [7:0] mask1Of2_q;
	reg [7:0] mask1Of3_q;
	reg [7:0] mask2Of2_q;
	reg [7:0] mask2Of3_q;
	wire [7:0] clear2;
	wire [7:0] clear3;
	wire wrAccess;
	wire addrHit;
	reg [31:0] rdMux;
	reg decodeOk;

	assign raw2[`HLIS_BIT_CHAN_STATUS_OK] = chanStatusOkLevel;
	assign raw2[`HLIS_BIT_INNER_SILENCE] = innerSilenceLevel;
	assign raw2[`HLIS_BIT_SOURCE_SILENCE] = sourceSilenceLevel;
	assign raw2[`HLIS_BIT_SOUND_LAYOUT] = soundLayoutLevel;
	assign raw2[`HLIS_BIT_LINK_TYPE] = linkTypeLevel;
	assign raw2[`HLIS_BIT_GENERAL_CTRL_PKT] = generalCtrlPktLevel;
	assign raw2[`HLIS_BIT_SOUND_CLK_REGEN] = soundClkRegenLevel;
	assign raw2[`HLIS_BIT_COLOUR_RANGE_META] = colourRangeMetaLevel;

	// third byte: bit 3 belongs to a source outside this block, held zero
	assign raw3[`HLIS_BIT_PORT2_PLUG] = port2PlugLevel;
	assign raw3[`HLIS_BIT_PORT1_PLL_LOCK] = port1PllLockLevel;
	assign raw3[`HLIS_BIT_PORT2_PLL_LOCK] = port2PllLockLevel;
	assign raw3[`HLIS_BIT_PORT1_CLK_SEEN] = port1ClkSeenLevel;
	assign raw3[3] = 1'b0;
	assign raw3[`HLIS_BIT_STEREO_VIDEO] = stereoVideoLevel;
	assign raw3[`HLIS_BIT_VSYNC_FILTER_LOCK] = vsyncFilterLockLevel;
	assign raw3[`HLIS_BIT_DE_REBUILD_LOCK] = deRebuildLockLevel;

	// prime flag: the first cycle after reset only loads the previous levels,
	// so a source that leaves reset high never reads as a change
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			rawValid_q <= 1'b0;
		else
			rawValid_q <= 1'b1;
	end

	// apb decode: zero wait states, every access completes in its access cycle
	assign pready = 1'b1;
	assign wrAccess = psel & penable & pwrite;
	assign addrHit = decodeOk;
	assign pslverr = psel & penable & ~addrHit; // unmapped address

	// write-one-to-clear strobes; only byte lane 0 carries the bits
	assign clear2 = (wrAccess && paddr == `HLIS_ADDR_CLEAR2 && pstrb[0]) ?
		pwdata[7:0] : 8'h00;
	assign clear3 = (wrAccess && paddr == `HLIS_ADDR_CLEAR3 && pstrb[0]) ?
		pwdata[7:0] : 8'h00;

	// one change flag per status bit; each holds its own previous level and
	// its own sticky bit, so the two bytes are just sixteen copies of it.
	// trade-off: a flop per bit for the previous level instead of a shared
	// byte store, bought for one place that owns set-versus-clear priority.
	// limitation: a level that toggles twice between two clock edges is
	// invisible; sources must hold each level for at least one cycle.
	// the prime input keeps every copy quiet on the first edge after reset.

	// second byte: audio and link state changes
	// channel status valid indication
	hlis_change_flag #(.RESET_VALUE(`HLIS_RST_FLAG)) u_chanStatusOkFlag (
		.mclk(mclk),
		.nrst(nrst),
		.primed(rawValid_q),
		.level(raw2[`HLIS_BIT_CHAN_STATUS_OK]),
		.clearReq(clear2[`HLIS_BIT_CHAN_STATUS_OK]),
		.flag(flagByte2[`HLIS_BIT_CHAN_STATUS_OK])
	);

	// internal mute indication
	hlis_change_flag #(.RESET_VALUE(`HLIS_RST_FLAG)) u_innerSilenceFlag (
		.mclk(mclk),
		.nrst(nrst),
		.primed(rawValid_q),
		.level(raw2[`HLIS_BIT_INNER_SILENCE]),
		.clearReq(clear2[`HLIS_BIT_INNER_SILENCE]),
		.flag(flagByte2[`HLIS_BIT_INNER_SILENCE])
	);

	// source-side mute detection
	hlis_change_flag #(.RESET_VALUE(`HLIS_RST_FLAG)) u_sourceSilenceFlag (
		.mclk(mclk),
		.nrst(nrst),
		.primed(rawValid_q),
		.level(raw2[`HLIS_BIT_SOURCE_SILENCE]),
		.clearReq(clear2[`HLIS_BIT_SOURCE_SILENCE]),
		.flag(flagByte2[`HLIS_BIT_SOURCE_SILENCE])
	);

	// audio channel layout indication
	hlis_change_flag #(.RESET_VALUE(`HLIS_RST_FLAG)) u_soundLayoutFlag (
		.mclk(mclk),
		.nrst(nrst),
		.primed(rawValid_q),
		.level(raw2[`HLIS_BIT_SOUND_LAYOUT]),
		.clearReq(clear2[`HLIS_BIT_SOUND_LAYOUT]),
		.flag(flagByte2[`HLIS_BIT_SOUND_LAYOUT])
	);

	// link type indication
	hlis_change_flag #(.RESET_VALUE(`HLIS_RST_FLAG)) u_linkTypeFlag (
		.mclk(mclk),
		.nrst(nrst),
		.primed(rawValid_q),
		.level(raw2[`HLIS_BIT_LINK_TYPE]),
		.clearReq(clear2[`HLIS_BIT_LINK_TYPE]),
		.flag(flagByte2[`HLIS_BIT_LINK_TYPE])
	);

	// general control packet indication
	hlis_change_flag #(.RESET_VALUE(`HLIS_RST_FLAG)) u_generalCtrlPktFlag (
		.mclk(mclk),
		.nrst(nrst),
		.primed(rawValid_q),
		.level(raw2[`HLIS_BIT_GENERAL_CTRL_PKT]),
		.clearReq(clear2[`HLIS_BIT_GENERAL_CTRL_PKT]),
		.flag(flagByte2[`HLIS_BIT_GENERAL_CTRL_PKT])
	);

	// audio clock regeneration packet indication
	hlis_change_flag #(.RESET_VALUE(`HLIS_RST_FLAG)) u_soundClkRegenFlag (
		.mclk(mclk),
		.nrst(nrst),
		.primed(rawValid_q),
		.level(raw2[`HLIS_BIT_SOUND_CLK_REGEN]),
		.clearReq(clear2[`HLIS_BIT_SOUND_CLK_REGEN]),
		.flag(flagByte2[`HLIS_BIT_SOUND_CLK_REGEN])
	);

	// colour range metadata packet indication
	hlis_change_flag #(.RESET_VALUE(`HLIS_RST_FLAG)) u_colourRangeMetaFlag (
		.mclk(mclk),
		.nrst(nrst),
		.primed(rawValid_q),
		.level(raw2[`HLIS_BIT_COLOUR_RANGE_META]),
		.clearReq(clear2[`HLIS_BIT_COLOUR_RANGE_META]),
		.flag(flagByte2[`HLIS_BIT_COLOUR_RANGE_META])
	);

	// third byte: port, clock and video lock changes
	// second port cable detect
	hlis_change_flag #(.RESET_VALUE(`HLIS_RST_FLAG)) u_port2PlugFlag (
		.mclk(mclk),
		.nrst(nrst),
		.primed(rawValid_q),
		.level(raw3[`HLIS_BIT_PORT2_PLUG]),
		.clearReq(clear3[`HLIS_BIT_PORT2_PLUG]),
		.flag(flagByte3[`HLIS_BIT_PORT2_PLUG])
	);

	// first port pll lock
	hlis_change_flag #(.RESET_VALUE(`HLIS_RST_FLAG)) u_port1PllLockFlag (
		.mclk(mclk),
		.nrst(nrst),
		.primed(rawValid_q),
		.level(raw3[`HLIS_BIT_PORT1_PLL_LOCK]),
		.clearReq(clear3[`HLIS_BIT_PORT1_PLL_LOCK]),
		.flag(flagByte3[`HLIS_BIT_PORT1_PLL_LOCK])
	);

	// second port pll lock
	hlis_change_flag #(.RESET_VALUE(`HLIS_RST_FLAG)) u_port2PllLockFlag (
		.mclk(mclk),
		.nrst(nrst),
		.primed(rawValid_q),
		.level(raw3[`HLIS_BIT_PORT2_PLL_LOCK]),
		.clearReq(clear3[`HLIS_BIT_PORT2_PLL_LOCK]),
		.flag(flagByte3[`HLIS_BIT_PORT2_PLL_LOCK])
	);

	// first port clock seen
	hlis_change_flag #(.RESET_VALUE(`HLIS_RST_FLAG)) u_port1ClkSeenFlag (
		.mclk(mclk),
		.nrst(nrst),
		.primed(rawValid_q),
		.level(raw3[`HLIS_BIT_PORT1_CLK_SEEN]),
		.clearReq(clear3[`HLIS_BIT_PORT1_CLK_SEEN]),
		.flag(flagByte3[`HLIS_BIT_PORT1_CLK_SEEN])
	);

	// second port clock: level tied low here, so the flag never sets
	hlis_change_flag #(.RESET_VALUE(`HLIS_RST_FLAG)) u_port2ClkSeenFlag (
		.mclk(mclk),
		.nrst(nrst),
		.primed(rawValid_q),
		.level(raw3[`HLIS_BIT_PORT2_CLK_SEEN]),
		.clearReq(clear3[`HLIS_BIT_PORT2_CLK_SEEN]),
		.flag(flagByte3[`HLIS_BIT_PORT2_CLK_SEEN])
	);

	// stereo video indication
	hlis_change_flag #(.RESET_VALUE(`HLIS_RST_FLAG)) u_stereoVideoFlag (
		.mclk(mclk),
		.nrst(nrst),
		.primed(rawValid_q),
		.level(raw3[`HLIS_BIT_STEREO_VIDEO]),
		.clearReq(clear3[`HLIS_BIT_STEREO_VIDEO]),
		.flag(flagByte3[`HLIS_BIT_STEREO_VIDEO])
	);

	// vertical sync filter lock
	hlis_change_flag #(.RESET_VALUE(`HLIS_RST_FLAG)) u_vsyncFilterLockFlag (
		.mclk(mclk),
		.nrst(nrst),
		.primed(rawValid_q),
		.level(raw3[`HLIS_BIT_VSYNC_FILTER_LOCK]),
		.clearReq(clear3[`HLIS_BIT_VSYNC_FILTER_LOCK]),
		.flag(flagByte3[`HLIS_BIT_VSYNC_FILTER_LOCK])
	);

	// data enable rebuild lock
	hlis_change_flag #(.RESET_VALUE(`HLIS_RST_FLAG)) u_deRebuildLockFlag (
		.mclk(mclk),
		.nrst(nrst),
		.primed(rawValid_q),
		.level(raw3[`HLIS_BIT_DE_REBUILD_LOCK]),
		.clearReq(clear3[`HLIS_BIT_DE_REBUILD_LOCK]),
		.flag(flagByte3[`HLIS_BIT_DE_REBUILD_LOCK])
	);

	// mask registers, one pair per interrupt output
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			mask1Of2_q <= `HLIS_RST_MASK;
			mask1Of3_q <= `HLIS_RST_MASK;
			mask2Of2_q <= `HLIS_RST_MASK;
			mask2Of3_q <= `HLIS_RST_MASK;
		end
		else if (wrAccess && pstrb[0])
		begin
			case (paddr)
				`HLIS_ADDR_MASK1_2: mask1Of2_q <= pwdata[7:0];
				`HLIS_ADDR_MASK1_3: mask1Of3_q <= pwdata[7:0];
				`HLIS_ADDR_MASK2_2: mask2Of2_q <= pwdata[7:0];
				`HLIS_ADDR_MASK2_3: mask2Of3_q <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// a flag only raises an output where that output's mask enables it
	assign firstIrqOutput = |(flagByte2 & mask1Of2_q) | |(flagByte3 & mask1Of3_q);
	assign secondIrqOutput = |(flagByte2 & mask2Of2_q) | |(flagByte3 & mask2Of3_q);

	// read mux and address decode; clear registers read as zero
	always @*
	begin
		rdMux = `HLIS_RST_RDATA;
		decodeOk = 1'b1;
		case (paddr)
			`HLIS_ADDR_STATUS2: rdMux = {24'h000000, flagByte2};
			`HLIS_ADDR_STATUS3: rdMux = {24'h000000, flagByte3};
			`HLIS_ADDR_CLEAR2: rdMux = `HLIS_RST_RDATA;
			`HLIS_ADDR_CLEAR3: rdMux = `HLIS_RST_RDATA;
			`HLIS_ADDR_MASK1_2: rdMux = {24'h000000, mask1Of2_q};
			`HLIS_ADDR_MASK1_3: rdMux = {24'h000000, mask1Of3_q};
			`HLIS_ADDR_MASK2_2: rdMux = {24'h000000, mask2Of2_q};
			`HLIS_ADDR_MASK2_3: rdMux = {24'h000000, mask2Of3_q};
			`HLIS_ADDR_RAW2: rdMux = {24'h000000, raw2};
			`HLIS_ADDR_RAW3: rdMux = {24'h000000, raw3};
			default: decodeOk = 1'b0;
		endcase
	end

	// read data registered in the setup cycle so it is stable in access
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			prdata <= `HLIS_RST_RDATA;
		else if (psel && !penable && !pwrite)
			prdata <= rdMux;
	end

endmodule

// one sticky change flag: edge detect on a raw level plus a held status bit
// a change in the clearing cycle wins, so no event is ever lost to a clear
module hlis_change_flag #(
	parameter RESET_VALUE = 1'b0
)(
	input wire mclk,
	input wire nrst,
	input wire primed,
	input wire level,
	input wire clearReq,
	output wire flag
);

	reg levelPrev_q;
	reg flag_q;
	reg flag_d;
	wire changed;

	// previous level, loaded every cycle so a change pulses exactly once
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			levelPrev_q <= 1'b0;
		else
			levelPrev_q <= level;
	end

	// either edge counts; held off until the previous level is primed
	assign changed = (level ^ levelPrev_q) & primed;

	// sticky next value: a return of the level never clears it
	always @*
	begin
		flag_d = (flag_q & ~clearReq) | changed;
	end

	// flag resets to zero, meaning no change seen
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			flag_q <= RESET_VALUE;
		else
			flag_q <= flag_d;
	end

	assign flag = flag_q;

endmodule

// >>> bench/hlis_status_latch_props.sv
// checker: irq stickiness, reset levels and read answers at the latch ports
// assumes: bound onto hlis_status_latch with its default address width
`timescale 1ns/10ps
`include "hlis_consts.vh"
module hlis_chk(
	input wire mclk,
	input wire nrst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire pslverr,
	input wire firstIrqOutput,
	input wire secondIrqOutput
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	// access phase, the only place a transfer is taken
	wire acc = psel && penable;
	property p_rst; disable iff (1'h0) !nrst |-> !firstIrqOutput && !secondIrqOutput; endproperty
	a_rst: assert property (p_rst) else $error("irq high in reset");
	property p_stick1; $fell(firstIrqOutput) |-> $past(acc && pwrite); endproperty
	a_stick1: assert property (p_stick1) else $error("irq1 fell without a write");
	property p_stick2; $fell(secondIrqOutput) |-> $past(acc && pwrite); endproperty
	a_stick2: assert property (p_stick2) else $error("irq2 fell without a write");
	property p_err; pslverr |-> acc; endproperty
	a_err: assert property (p_err) else $error("error outside access");
	property p_errz; acc && pslverr && !pwrite |-> prdata == 32'h0; endproperty
	a_errz: assert property (p_errz) else $error("unmapped read not zero");
	property p_hi; acc && !pwrite |-> prdata[31:8] == 24'h0; endproperty
	a_hi: assert property (p_hi) else $error("upper read bits set");
	property p_b3; acc && !pwrite && paddr == `HLIS_ADDR_STATUS3 |-> !prdata[3]; endproperty
	a_b3: assert property (p_b3) else $error("unsourced bit set");
	property p_map; acc && paddr == `HLIS_ADDR_STATUS2 |-> !pslverr; endproperty
	a_map: assert property (p_map) else $error("status read refused");
	cover property (acc && pslverr);
	cover property ($rose(firstIrqOutput));
	cover property ($rose(secondIrqOutput));
endmodule
bind hlis_status_latch hlis_chk u_hlis_chk(.mclk(mclk), .nrst(nrst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
	.firstIrqOutput(firstIrqOutput), .secondIrqOutput(secondIrqOutput));

// >>> bench/tb.sv
// testbench: random raw toggles, sticky status reads and masked irqs over APB
// assumes: design and checker compiled first; zero wait state slave
`timescale 1ns/10ps
`include "hlis_consts.vh"
module tb;
	reg mclk = 1'h0, nrst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	reg [11:0] paddr = 12'h0;
	reg [31:0] pwdata = 32'h0;
	reg [3:0] pstrb = 4'hF;
	reg [15:0] raw = 16'h0, lf = 16'h002F, st;
	reg [7:0] m1, m2;
	reg [34:0] e;
	reg [34:0] q[$];
	wire [31:0] prdata;
	wire pready, pslverr, i1, i2;
	integer fails = 0, compares = 0, k;
	always #12.5 mclk = ~mclk;
	// raw[15:8] feed the second byte, raw[7:0] the third; raw[3] has no source
	hlis_status_latch u_hlis_status_latch(.mclk(mclk), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .chanStatusOkLevel(raw[15]),
		.innerSilenceLevel(raw[14]), .sourceSilenceLevel(raw[13]), .soundLayoutLevel(raw[12]),
		.linkTypeLevel(raw[11]), .generalCtrlPktLevel(raw[10]), .soundClkRegenLevel(raw[9]),
		.colourRangeMetaLevel(raw[8]), .port2PlugLevel(raw[7]), .port1PllLockLevel(raw[6]),
		.port2PllLockLevel(raw[5]), .port1ClkSeenLevel(raw[4]), .stereoVideoLevel(raw[2]),
		.vsyncFilterLockLevel(raw[1]), .deRebuildLockLevel(raw[0]),
		.firstIrqOutput(i1), .secondIrqOutput(i2));
	function [15:0] nx(input [15:0] v);
		nx = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task chk(input [34:0] s, input [34:0] x);
	begin
		compares = compares + 1;
		if (s !== x)
		begin
			fails = fails + 1;
			$display("unexpected at %0t: saw %h want %h", $time, s, x);
		end
	end
	endtask
	task end_of_test;
	begin
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	end
	endtask
	// raw levels flip with the access phase so they land on the taking edge
	task apb(input w, input [11:0] a, input [31:0] d, input [15:0] tg);
	begin
		@(posedge mclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'h1;
		raw <= raw ^ tg;
		@(posedge mclk);
		while (pready !== 1'h1)
			@(posedge mclk);
		psel <= 1'h0;
		penable <= 1'h0;
	end
	endtask
	task rd(input [11:0] a, input [34:0] x);
	begin
		q.push_back(x);
		apb(1'h0, a, 32'h0, 16'h0);
	end
	endtask
	// monitor: error, both irqs and read data against the oldest note
	always @(posedge mclk)
		if (psel && penable && !pwrite && pready)
			chk({pslverr, i2, i1, prdata}, q.pop_front());
	initial
	begin
		#200000;
		fails = fails + 1;
		end_of_test;
	end
	initial
	begin
		nrst <= 1'h0;
		repeat (5) @(posedge mclk);
		nrst <= 1'h1;
		rd(`HLIS_ADDR_STATUS2, 35'h0);
		rd(`HLIS_ADDR_STATUS3, 35'h0);
		rd(`HLIS_ADDR_MASK1_2, 35'h0);
		rd(12'hFFC, 35'h400000000);
		pstrb <= 4'hE;
		apb(1'h1, `HLIS_ADDR_MASK1_2, 32'hFF, 16'h0);
		pstrb <= 4'hF;
		rd(`HLIS_ADDR_MASK1_2, 35'h0);
		$display("reset test done");
		for (k = 0; k < 6; k = k + 1)
		begin
			lf = nx(lf);
			st = lf & 16'hFFF7;
			m1 = lf[7:0] ^ lf[15:8];
			m2 = ~lf[15:8];
			apb(1'h1, `HLIS_ADDR_CLEAR2, 32'hFF, 16'h0);
			apb(1'h1, `HLIS_ADDR_CLEAR3, 32'hFF, lf);
			apb(1'h1, `HLIS_ADDR_MASK1_2, {24'h0, m1}, 16'h0);
			apb(1'h1, `HLIS_ADDR_MASK1_3, {24'h0, m2}, 16'h0);
			apb(1'h1, `HLIS_ADDR_MASK2_2, {24'h0, m2}, 16'h0);
			apb(1'h1, `HLIS_ADDR_MASK2_3, {24'h0, m1}, 16'h0);
			e = {1'h0, |(st[15:8] & m2) | |(st[7:0] & m1), |(st[15:8] & m1) | |(st[7:0] & m2),
				32'h0};
			// second pass follows a return of every raw level via a read-only write
			repeat (2)
			begin
				rd(`HLIS_ADDR_STATUS2, e | st[15:8]);
				rd(`HLIS_ADDR_STATUS3, e | st[7:0]);
				rd(`HLIS_ADDR_RAW2, e | raw[15:8]);
				rd(`HLIS_ADDR_RAW3, e | (raw[7:0] & 8'hF7));
				apb(1'h1, `HLIS_ADDR_STATUS2, 32'h0, lf);
			end
			$display("pattern test %0d done", k);
		end
		end_of_test;
	end
endmodule
